// >>> ulc_cfg.svh
// ulc_cfg.svh: register offsets, field positions, reset values and counts for the line control block.
// assumes an 8-bit CPU I/O bus with 16-bit addresses; one channel per instance.
//
// Contract
// - divisor access 0 maps shared addresses to receive, transmit holding, interrupt enable.
// - divisor access 1 maps shared addresses to baud divisor low and high.
// - send break drives zero from the next bit boundary, ignoring the shifter.
// - entering break discards the character in the transmit shifter.
// - transmit FIFO is cleared on the same bit edge that forces the output low.
// - data written during break is held and sent after recovery.
// - clearing send break resumes transmit at the next baud generator edge.
// - force parity error with parity enable inverts transmitted parity.
// - even select 0 without multidrop gives odd parity, sent and checked.
// - even select 1 without multidrop gives even parity, sent and checked.
// - parity enable 0 means no parity bit sent or checked.
// - parity enable 1 appends parity to every character and checks every one.
// - multidrop checks received parity as space.
// - multidrop with even select 0 transmits a space parity bit.
// - multidrop with even select 1 transmits a mark parity bit.
// - multidrop clears even select after the first transmitted character.
// - three-bit format field selects 5 to 8 data bits and 1 or 2 stops.
// - multidrop enable is modem control bit 5, combined with even select.
`ifndef ULC_CFG_SVH
`define ULC_CFG_SVH
`define ULC_BASE_CH0 16'h00C0
`define ULC_BASE_CH1 16'h00D0
`define ULC_LINE_CONTROL_CH0 16'h00C3
`define ULC_LINE_CONTROL_CH1 16'h00D3
`define ULC_OFS_DATA 4'h0
`define ULC_OFS_IER 4'h1
`define ULC_OFS_FCTL 4'h2
`define ULC_OFS_LCTL 4'h3
`define ULC_OFS_MCTL 4'h4
`define ULC_OFS_LSR 4'h5
`define ULC_LCTL_RESET 8'h00
`define ULC_MCTL_RESET 8'h00
`define ULC_IER_RESET 8'h00
`define ULC_DIV_RESET 16'h0000
`define ULC_BIT_DIVISOR_LATCH_ACCESS 7
`define ULC_BIT_BREAK 6
`define ULC_BIT_FPE 5
`define ULC_BIT_EPS 4
`define ULC_BIT_PEN 3
`define ULC_BIT_STOP2 2
`define ULC_BIT_MDM 5
`define ULC_BIT_CLRTX 2
`define ULC_LSR_DR 0
`define ULC_LSR_PE 2
`define ULC_LSR_TX_HOLDING_EMPTY 5
`define ULC_LSR_TEMT 6
`define ULC_OVERSAMPLE 4'hF
`define ULC_MID_SAMPLE 4'h7
`define ULC_MIN_BITS 4'h5
`endif

// >>> ulc_pkg.sv
// ulc_pkg: state types of the line control block.
// assumes ulc_cfg.svh supplies all numeric constants.
package ulc_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ulc_tx_state_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ulc_rx_state_type;
endpackage

// >>> ulc_line_control.sv
// ulc_line_control: transmit FIFO plus one serial channel governed by the line control register.
// assumes one clock, synchronous active-low reset, rxd arriving asynchronously from the pin.
`timescale 1ns/1ns
`include "ulc_cfg.svh"

module ulc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// flush
	input wire logic flush,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
			$error("fifo depth must be a power of two, at least 2");
		end
	endgenerate
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic push, pop;

	assign inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
	assign outValid = wrPtr_r != rdPtr_r;
	assign outData = mem[rdPtr_r[AW-1:0]];
	assign push = inValid && inReady && !flush;
	assign pop = outValid && outReady && !flush;

	always_comb begin
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		if (flush) begin
			wrPtr_nxt = '0;
			rdPtr_nxt = '0;
		end else begin
			if (push)
				wrPtr_nxt = wrPtr_r + 1'b1;
			if (pop)
				rdPtr_nxt = rdPtr_r + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
		end
	end

	// storage has no reset: contents are only read behind a valid pointer pair
	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wrPtr_r[AW-1:0]] <= inData;
	end
endmodule

module ulc_line_control #(
	parameter int CHANNEL = 0,
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// cpu i/o bus
	input wire logic [15:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioWrData,
	output logic [7:0] ioRdData,
	output logic txAccept,
	// serial pins
	output logic txd,
	input wire logic rxd
);
	import ulc_pkg::*;
	generate
		if (CHANNEL < 0 || CHANNEL > 1) begin : g_chk
			$error("channel must be 0 or 1");
		end
	endgenerate

	localparam logic [15:0] BASE = (CHANNEL == 0) ? `ULC_BASE_CH0 : `ULC_BASE_CH1;
	localparam logic [15:0] LCTL_ADDR = (CHANNEL == 0) ? `ULC_LINE_CONTROL_CH0 : `ULC_LINE_CONTROL_CH1;
	// the offset decode below assumes line control sits at its fixed offset in the window
	generate
		if (LCTL_ADDR != (BASE | 16'(`ULC_OFS_LCTL))) begin : g_map
			$error("line control offset does not match the channel window");
		end
	endgenerate

	// parity of the used data bits; oddSel picks odd parity
	function automatic logic parityOf(input logic [7:0] d, input logic [1:0] len, input logic oddSel);
		logic [7:0] m;
		m = 8'hFF >> (2'd3 - len);
		return (^(d & m)) ^ oddSel;
	endfunction

	// expected parity bit for the current line settings
	function automatic logic parityBit(input logic [7:0] d, input logic [7:0] lc, input logic multidrop_enable);
		if (multidrop_enable)
			return lc[`ULC_BIT_EPS];
		return parityOf(d, lc[1:0], !lc[`ULC_BIT_EPS]);
	endfunction

	logic [7:0] lineControl_r, lineControl_nxt, modemControl_r, modemControl_nxt, intEnable_r, intEnable_nxt;
	logic [15:0] divisor_r, divisor_nxt;
	logic [7:0] rdData_r, rdData_nxt, rxBuf_r, rxBuf_nxt;
	logic dataReady_r, dataReady_nxt, parityErr_r, parityErr_nxt;
	logic hit, divisor_latch_access, multidrop_enable, parity_enable, breakReq;
	logic [3:0] ofs;
	logic fifoInValid, fifoInReady, fifoOutValid, fifoPop, fifoFlush;
	logic [7:0] fifoOutData;
	logic charDone, rxDone, rxParOk, charBusy;
	logic [7:0] rxShift_r, rxShift_nxt;

	assign hit = (ioAddr[15:4] == BASE[15:4]);
	assign ofs = ioAddr[3:0];
	assign divisor_latch_access = lineControl_r[`ULC_BIT_DIVISOR_LATCH_ACCESS];
	assign multidrop_enable = modemControl_r[`ULC_BIT_MDM];
	assign parity_enable = lineControl_r[`ULC_BIT_PEN];
	assign breakReq = lineControl_r[`ULC_BIT_BREAK];
	assign fifoInValid = hit && ioWrite && ofs == `ULC_OFS_DATA && !divisor_latch_access;
	assign txAccept = fifoInValid && fifoInReady;

	// register file
	always_comb begin
		lineControl_nxt = lineControl_r;
		modemControl_nxt = modemControl_r;
		intEnable_nxt = intEnable_r;
		divisor_nxt = divisor_r;
		rdData_nxt = rdData_r;
		rxBuf_nxt = rxBuf_r;
		dataReady_nxt = dataReady_r;
		parityErr_nxt = parityErr_r;
		// hardware clears even select first so that a software write in the same cycle wins
		if (charDone && multidrop_enable)
			lineControl_nxt[`ULC_BIT_EPS] = 1'b0;
		if (hit && ioRead) begin
			rdData_nxt = 8'h00;
			unique case (ofs)
				`ULC_OFS_DATA: begin
					rdData_nxt = divisor_latch_access ? divisor_r[7:0] : rxBuf_r;
					if (!divisor_latch_access)
						dataReady_nxt = 1'b0;
				end
				`ULC_OFS_IER: rdData_nxt = divisor_latch_access ? divisor_r[15:8] : intEnable_r;
				`ULC_OFS_LCTL: rdData_nxt = lineControl_r;
				`ULC_OFS_MCTL: rdData_nxt = modemControl_r;
				`ULC_OFS_LSR: begin
					rdData_nxt[`ULC_LSR_DR] = dataReady_r;
					rdData_nxt[`ULC_LSR_PE] = parityErr_r;
					rdData_nxt[`ULC_LSR_TX_HOLDING_EMPTY] = !fifoOutValid;
					rdData_nxt[`ULC_LSR_TEMT] = !fifoOutValid && !charBusy;
					parityErr_nxt = 1'b0;
				end
				default: rdData_nxt = 8'h00;
			endcase
		end
		if (hit && ioWrite) begin
			unique case (ofs)
				`ULC_OFS_DATA: begin
					if (divisor_latch_access)
						divisor_nxt[7:0] = ioWrData;
				end
				`ULC_OFS_IER: begin
					if (divisor_latch_access)
						divisor_nxt[15:8] = ioWrData;
					else
						intEnable_nxt = ioWrData;
				end
				`ULC_OFS_LCTL: lineControl_nxt = ioWrData;
				`ULC_OFS_MCTL: modemControl_nxt = {2'b00, ioWrData[5:0]};
				default: ;
			endcase
		end
		// a fresh character beats a same-cycle read clear
		if (rxDone) begin
			rxBuf_nxt = rxShift_r;
			dataReady_nxt = 1'b1;
			if (!rxParOk)
				parityErr_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			lineControl_r <= `ULC_LCTL_RESET;
			modemControl_r <= `ULC_MCTL_RESET;
			intEnable_r <= `ULC_IER_RESET;
			divisor_r <= `ULC_DIV_RESET;
			rdData_r <= 8'h00;
			rxBuf_r <= 8'h00;
			dataReady_r <= 1'b0;
			parityErr_r <= 1'b0;
		end else begin
			lineControl_r <= lineControl_nxt;
			modemControl_r <= modemControl_nxt;
			intEnable_r <= intEnable_nxt;
			divisor_r <= divisor_nxt;
			rdData_r <= rdData_nxt;
			rxBuf_r <= rxBuf_nxt;
			dataReady_r <= dataReady_nxt;
			parityErr_r <= parityErr_nxt;
		end
	end
	assign ioRdData = rdData_r;

	// baud generator: one tick per divisor clocks, sixteen ticks per bit; divisor 0 stops it
	logic [15:0] baudCnt_r, baudCnt_nxt;
	logic [3:0] phase_r, phase_nxt;
	logic tick, bitEdge;
	assign tick = (divisor_r != 16'h0000) && (baudCnt_r == divisor_r - 16'h0001);
	assign bitEdge = tick && phase_r == `ULC_OVERSAMPLE;

	always_comb begin
		baudCnt_nxt = tick || divisor_r == 16'h0000 ? 16'h0000 : baudCnt_r + 16'h0001;
		phase_nxt = tick ? phase_r + 4'h1 : phase_r;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			baudCnt_r <= 16'h0000;
			phase_r <= 4'h0;
		end else begin
			baudCnt_r <= baudCnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	// transmitter
	ulc_tx_state_type txState_r, txState_nxt;
	logic [7:0] txShift_r, txShift_nxt;
	logic [2:0] txCount_r, txCount_nxt;
	logic breakOn_r, breakOn_nxt, txd_r, txd_nxt;
	assign charBusy = txState_r != TX_IDLE;
	assign fifoFlush = breakReq && !breakOn_r && bitEdge;
	assign fifoPop = txState_r == TX_IDLE && !breakOn_r && !breakReq && bitEdge;

	always_comb begin
		txState_nxt = txState_r;
		txShift_nxt = txShift_r;
		txCount_nxt = txCount_r;
		breakOn_nxt = breakOn_r;
		txd_nxt = txd_r;
		charDone = 1'b0;
		if (breakOn_r) begin
			txd_nxt = 1'b0;
			if (!breakReq && tick) begin
				breakOn_nxt = 1'b0;
				txd_nxt = 1'b1;
			end
		end else if (breakReq && bitEdge) begin
			breakOn_nxt = 1'b1;
			txState_nxt = TX_IDLE;
			txd_nxt = 1'b0;
		end else if (bitEdge) begin
			unique case (txState_r)
				TX_IDLE: begin
					txd_nxt = 1'b1;
					if (fifoOutValid) begin
						txShift_nxt = fifoOutData;
						txCount_nxt = 3'd0;
						txd_nxt = 1'b0;
						txState_nxt = TX_DATA;
					end
				end
				TX_START: txState_nxt = TX_DATA;
				TX_DATA: begin
					txd_nxt = txShift_r[txCount_r];
					txCount_nxt = txCount_r + 3'd1;
					if (txCount_r == {1'b0, lineControl_r[1:0]} + 3'd4)
						txState_nxt = parity_enable ? TX_PARITY : TX_STOP;
				end
				TX_PARITY: begin
					txd_nxt = parityBit(txShift_r, lineControl_r, multidrop_enable) ^ lineControl_r[`ULC_BIT_FPE];
					txCount_nxt = 3'd0;
					txState_nxt = TX_STOP;
				end
				TX_STOP: begin
					txd_nxt = 1'b1;
					txCount_nxt = txCount_r + 3'd1;
					if (txCount_r == {2'b00, lineControl_r[`ULC_BIT_STOP2]} || !parity_enable && txCount_r[2]) begin
						txState_nxt = TX_IDLE;
						charDone = 1'b1;
					end
				end
			endcase
			if (txState_r == TX_DATA && txCount_r == {1'b0, lineControl_r[1:0]} + 3'd4 && !parity_enable)
				txCount_nxt = 3'd0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			txState_r <= TX_IDLE;
			txShift_r <= 8'h00;
			txCount_r <= 3'd0;
			breakOn_r <= 1'b0;
			txd_r <= 1'b1;
		end else begin
			txState_r <= txState_nxt;
			txShift_r <= txShift_nxt;
			txCount_r <= txCount_nxt;
			breakOn_r <= breakOn_nxt;
			txd_r <= txd_nxt;
		end
	end
	assign txd = txd_r;

	ulc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txfifo (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.flush(fifoFlush || hit && ioWrite && ofs == `ULC_OFS_FCTL && ioWrData[`ULC_BIT_CLRTX]),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(ioWrData),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);

	// receiver: rxd passes two flops, then sampled mid-bit on the sixteenth-bit ticks
	logic rxMeta_r, rxSync_r;
	ulc_rx_state_type rxState_r, rxState_nxt;
	logic [3:0] rxPhase_r, rxPhase_nxt;
	logic [2:0] rxCount_r, rxCount_nxt;
	logic rxParOk_r, rxParOk_nxt, mid;
	assign mid = tick && rxPhase_r == `ULC_MID_SAMPLE;
	assign rxParOk = rxParOk_r;

	always_comb begin
		rxState_nxt = rxState_r;
		rxPhase_nxt = tick ? rxPhase_r + 4'h1 : rxPhase_r;
		rxCount_nxt = rxCount_r;
		rxShift_nxt = rxShift_r;
		rxParOk_nxt = rxParOk_r;
		rxDone = 1'b0;
		unique case (rxState_r)
			RX_IDLE: begin
				rxPhase_nxt = 4'h0;
				if (!rxSync_r)
					rxState_nxt = RX_START;
			end
			RX_START: begin
				if (mid) begin
					rxState_nxt = rxSync_r ? RX_IDLE : RX_DATA;
					rxCount_nxt = 3'd0;
					rxShift_nxt = 8'h00;
					rxParOk_nxt = 1'b1;
				end
			end
			RX_DATA: begin
				if (mid) begin
					rxShift_nxt[rxCount_r] = rxSync_r;
					rxCount_nxt = rxCount_r + 3'd1;
					if (rxCount_r == {1'b0, lineControl_r[1:0]} + 3'd4)
						rxState_nxt = parity_enable ? RX_PARITY : RX_STOP;
				end
			end
			RX_PARITY: begin
				if (mid) begin
					rxParOk_nxt = rxSync_r == (multidrop_enable ? 1'b0 : parityBit(rxShift_r, lineControl_r, 1'b0));
					rxState_nxt = RX_STOP;
				end
			end
			RX_STOP: begin
				if (mid) begin
					rxDone = 1'b1;
					rxState_nxt = RX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rxMeta_r <= 1'b1;
			rxSync_r <= 1'b1;
			rxState_r <= RX_IDLE;
			rxPhase_r <= 4'h0;
			rxCount_r <= 3'd0;
			rxShift_r <= 8'h00;
			rxParOk_r <= 1'b1;
		end else begin
			rxMeta_r <= rxd;
			rxSync_r <= rxMeta_r;
			rxState_r <= rxState_nxt;
			rxPhase_r <= rxPhase_nxt;
			rxCount_r <= rxCount_nxt;
			rxShift_r <= rxShift_nxt;
			rxParOk_r <= rxParOk_nxt;
		end
	end
endmodule

// >>> ulc_line_control_properties.sv
// ulc_line_control_properties: port-level assertions for the line control block.
// assumes it is bound to every ulc_line_control instance and mirrors registers from bus writes.
`timescale 1ns/1ns
`include "ulc_cfg.svh"
module ulc_line_control_properties #(
	parameter int CHANNEL = 0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// watched ports
	input wire logic [15:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioWrData,
	input wire logic [7:0] ioRdData,
	input wire logic txAccept,
	input wire logic txd,
	input wire logic rxd
);
	localparam logic [15:0] BASE = CHANNEL ? `ULC_BASE_CH1 : `ULC_BASE_CH0;
	logic [7:0] lc_r, ier_r, mc_r, dl_r, dh_r;
	logic [19:0] sb_r;
	wire hit = ioAddr[15:4] == BASE[15:4];
	wire wr = ioWrite && hit;
	wire rd = ioRead && !ioWrite && hit;
	wire [3:0] ofs = ioAddr[3:0];
	// bit 4 of line control may be cleared by hardware, so its reads are masked
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			lc_r <= 8'h00;
			ier_r <= 8'h00;
			mc_r <= 8'h00;
			dl_r <= 8'h00;
			dh_r <= 8'h00;
			sb_r <= 20'h0;
		end else begin
			if (wr && ofs == 4'h3) lc_r <= ioWrData;
			if (wr && ofs == 4'h4) mc_r <= ioWrData & 8'h3F;
			if (wr && ofs == 4'h1 && !lc_r[7]) ier_r <= ioWrData;
			if (wr && ofs == 4'h0 && lc_r[7]) dl_r <= ioWrData;
			if (wr && ofs == 4'h1 && lc_r[7]) dh_r <= ioWrData;
			sb_r <= lc_r[6] ? sb_r + 20'h1 : 20'h0;
		end
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	thr_accept_a: assert property (txAccept |-> wr && ofs == 4'h0 && !lc_r[7])
		else $error("transmit accept outside a holding write");
	ier_read_a: assert property (rd && ofs == 4'h1 && !lc_r[7] |=> ioRdData == $past(ier_r))
		else $error("interrupt enable readback wrong");
	div_low_a: assert property (rd && ofs == 4'h0 && lc_r[7] |=> ioRdData == $past(dl_r))
		else $error("divisor low readback wrong");
	div_high_a: assert property (rd && ofs == 4'h1 && lc_r[7] |=> ioRdData == $past(dh_r))
		else $error("divisor high readback wrong");
	line_read_a: assert property (rd && ofs == 4'h3 |=> (ioRdData & 8'hEF) == ($past(lc_r) & 8'hEF))
		else $error("line control readback wrong");
	modem_read_a: assert property (rd && ofs == 4'h4 |=> ioRdData == $past(mc_r))
		else $error("modem control readback wrong");
	break_low_a: assert property (lc_r[6] && {dh_r, dl_r} != 16'h0 && sb_r > {dh_r, dl_r, 4'h3} |-> !txd)
		else $error("serial output not low during break");
	stopped_line_a: assert property ({dh_r, dl_r} == 16'h0 |=> $stable(txd))
		else $error("serial output moved without baud edges");
	cover property (lc_r[6] && !txd);
	cover property (rd && ofs == 4'h0 && lc_r[7]);
	cover property (wr && ofs == 4'h0 && !lc_r[7] && !txAccept);
	cover property (mc_r[5] && lc_r[3] && $fell(txd));
	cover property ($fell(rxd) && !lc_r[6]);
endmodule
bind ulc_line_control ulc_line_control_properties #(.CHANNEL(CHANNEL)) props_u (
	.ref_clk(ref_clk), .rst_b(rst_b), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
	.ioWrData(ioWrData), .ioRdData(ioRdData), .txAccept(txAccept), .txd(txd), .rxd(rxd));

// >>> ulc_remote_station.sv
// ulc_remote_station: far station that decodes frames off txd and echoes txd back on rxd.
// assumes a bit time of BIT_CLKS ref_clk cycles and the format given on its inputs.
`timescale 1ns/1ns
module ulc_remote_station #(
	parameter int BIT_CLKS = 32
) (
	// clock
	input wire logic ref_clk,
	// line
	input wire logic txd,
	output logic rxd,
	// format and decoded word
	input wire logic [3:0] nBits,
	input wire logic withParity,
	output logic gotValid,
	output logic [8:0] gotWord
);
	logic [8:0] w;
	// loopback far end, so the block's receiver checks every frame it sends
	always @(posedge ref_clk)
		rxd <= txd;
	initial begin
		gotValid = 1'b0;
		gotWord = 9'h000;
		forever begin
			@(negedge txd);
			repeat (BIT_CLKS / 2) @(posedge ref_clk);
			w = 9'h000;
			for (int i = 0; i < nBits + withParity; i++) begin
				repeat (BIT_CLKS) @(posedge ref_clk);
				w[i < nBits ? i : 8] = txd;
			end
			repeat (BIT_CLKS) @(posedge ref_clk);
			// a low stop sample means a frame cut by a break; it is not reported
			if (txd) begin
				gotWord <= w;
				gotValid <= 1'b1;
				@(posedge ref_clk);
				gotValid <= 1'b0;
			end
		end
	end
endmodule

// >>> test_ulc_line_control.sv
// test_ulc_line_control: self-checking bench for channel 0 of the line control block.
// assumes the remote station decodes txd at divisor 2, that is 32 clocks a bit.
`timescale 1ns/1ns
`include "ulc_cfg.svh"
module test_ulc_line_control;
	localparam logic [15:0] B = `ULC_BASE_CH0;
	logic ref_clk = 1'b0;
	logic rst_b;
	logic [15:0] ioAddr;
	logic ioWrite;
	logic ioRead;
	logic [7:0] ioWrData;
	logic [7:0] ioRdData;
	logic txAccept, txd, rxd, gotValid;
	logic rdPend = 1'b0;
	logic [8:0] gotWord, e;
	logic [3:0] nBits;
	logic withParity;
	logic [31:0] seed = 32'hC0AF;
	logic [8:0] expRd[$];
	logic [9:0] expFr[$];
	logic expAcc[$];
	int n_mismatch = 0;
	int tests_run = 0;
	initial forever #50 ref_clk = ~ref_clk;
	ulc_line_control #(.CHANNEL(0), .FIFO_DEPTH(8)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .ioAddr(ioAddr),
		.ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .txAccept(txAccept),
		.txd(txd), .rxd(rxd));
	ulc_remote_station #(.BIT_CLKS(32)) far_u (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .nBits(nBits),
		.withParity(withParity), .gotValid(gotValid), .gotWord(gotWord));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmpReg(input logic [7:0] x, input logic [7:0] g);
		tests_run++;
		if (x !== g) begin
			n_mismatch++;
			$display("Error register expected %h seen %h", x, g);
		end
	endtask
	task automatic cmpAccept(input logic x, input logic g);
		tests_run++;
		if (x !== g) begin
			n_mismatch++;
			$display("Error accept expected %b seen %b", x, g);
		end
	endtask
	// bit 9 of the expectation marks a frame that should not have appeared
	task automatic cmpFrame(input logic [9:0] x, input logic [9:0] g);
		tests_run++;
		if (x !== g) begin
			n_mismatch++;
			$display("Error frame expected %h seen %h", x, g);
		end
	endtask
	task automatic fail(input string what);
		n_mismatch++;
		$display("Error %s timeout", what);
		end_sim();
	endtask
	task automatic wrReg(input logic [3:0] ofs, input logic [7:0] d);
		@(posedge ref_clk);
		ioWrite <= 1'b1;
		ioAddr <= B + 16'(ofs);
		ioWrData <= d;
		@(posedge ref_clk);
		ioWrite <= 1'b0;
	endtask
	// bit 8 of the note marks a read whose value is not compared
	task automatic rdReg(input logic [3:0] ofs, input logic [8:0] x);
		expRd.push_back(x);
		@(posedge ref_clk);
		ioRead <= 1'b1;
		ioAddr <= B + 16'(ofs);
		@(posedge ref_clk);
		ioRead <= 1'b0;
	endtask
	task automatic waitDrain();
		for (int k = 0; k < 20000 && expFr.size() > 0; k++) @(posedge ref_clk);
		if (expFr.size() > 0) fail("frame");
		// room for a second stop bit before the format changes
		repeat (64) @(posedge ref_clk);
	endtask
	task automatic sendChar(input logic [7:0] lc, input logic md);
		logic [7:0] d;
		logic p;
		logic pe;
		seed = lfsr(seed);
		d = seed[7:0] & (8'hFF >> (3 - lc[1:0]));
		p = md ? lc[4] : ^d ^ !lc[4] ^ lc[5];
		// the echoed frame fails its check when exactly one holds: parity was forced, or a mark meets the space check
		pe = lc[3] & (lc[5] ^ (md & lc[4]));
		nBits <= 4'(lc[1:0]) + 4'h5;
		withParity <= lc[3];
		wrReg(4'h3, lc);
		expFr.push_back({1'b0, p & lc[3], d});
		expAcc.push_back(1'b1);
		wrReg(4'h0, seed[7:0]);
		waitDrain();
		rdReg(4'h0, {1'b0, d});
		rdReg(4'h5, {1'b0, 5'b01100, pe, 2'b00});
	endtask
	always @(posedge ref_clk) begin
		rdPend <= ioRead;
		if (rdPend) begin
			e = expRd.pop_front();
			if (!e[8]) cmpReg(e[7:0], ioRdData);
		end
		if (ioWrite && ioAddr == B && expAcc.size() > 0) cmpAccept(expAcc.pop_front(), txAccept);
		if (gotValid) cmpFrame(expFr.size() > 0 ? expFr.pop_front() : 10'h3FF, {1'b0, gotWord});
	end
	initial begin
		logic rdy;
		rst_b <= 1'b0;
		ioAddr <= 16'h0000;
		ioWrite <= 1'b0;
		ioRead <= 1'b0;
		ioWrData <= 8'h00;
		nBits <= 4'h8;
		withParity <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdReg(4'h3, 9'h000);
		rdReg(4'h4, 9'h000);
		rdReg(4'h1, 9'h000);
		wrReg(4'h1, 8'h0F);
		wrReg(4'h3, 8'h03);
		// divisor is still 0, so the buffer only fills until it refuses
		for (int i = 0; i < 9; i++) begin
			expAcc.push_back(i < 8);
			if (i < 8) expFr.push_back({2'b00, 8'h30 + 8'(i)});
			wrReg(4'h0, 8'h30 + 8'(i));
		end
		wrReg(4'h3, 8'h83);
		wrReg(4'h0, 8'h02);
		wrReg(4'h1, 8'h00);
		rdReg(4'h0, 9'h002);
		rdReg(4'h1, 9'h000);
		wrReg(4'h3, 8'h03);
		rdReg(4'h1, 9'h00F);
		waitDrain();
		for (int k = 0; k < 64; k++) sendChar({2'b00, 6'(k)}, 1'b0);
		wrReg(4'h4, 8'h20);
		rdReg(4'h4, 9'h020);
		sendChar(8'h1B, 1'b1);
		rdReg(4'h3, 9'h00B);
		sendChar(8'h0B, 1'b1);
		wrReg(4'h4, 8'h00);
		nBits <= 4'h8;
		withParity <= 1'b0;
		wrReg(4'h3, 8'h03);
		for (int i = 1; i < 4; i++) begin
			expAcc.push_back(1'b1);
			wrReg(4'h0, 8'(i * 17));
		end
		for (int k = 0; k < 500 && txd; k++) @(posedge ref_clk);
		if (txd) fail("start bit");
		repeat (64) @(posedge ref_clk);
		wrReg(4'h3, 8'h43);
		rdy = 1'b0;
		for (int k = 0; k < 100 && !rdy; k++) begin
			rdReg(4'h5, 9'h100);
			@(posedge ref_clk);
			rdy = ioRdData[5];
		end
		if (!rdy) fail("holding empty");
		expAcc.push_back(1'b1);
		expFr.push_back(10'h0A5);
		wrReg(4'h0, 8'hA5);
		repeat (400) @(posedge ref_clk);
		wrReg(4'h3, 8'h03);
		waitDrain();
		end_sim();
	end
endmodule
